// ### bench/tb.sv
// Self-checking testbench for the watchdog timer subsystem.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic rom; logic ea; logic [7:0] addr; logic [7:0] exp;} wdt_row_s;
    localparam wdt_row_s ROWS [7] = '{'{1'b0, 1'b0, 8'hc4, 8'hfb}, '{1'b0, 1'b0, 8'hc1, 8'h00},
        '{1'b0, 1'b0, 8'hc2, 8'h00}, '{1'b0, 1'b0, 8'hc3, 8'h00}, '{1'b0, 1'b0, 8'h80, 8'h00},
        '{1'b0, 1'b0, 8'h87, 8'h00}, '{1'b1, 1'b1, 8'hc4, 8'he2}};
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, por_i = 1'b1, rom_variant_i = 1'b0;
    logic external_access_select_i = 1'b0, low_voltage_i = 1'b0, osc_fail_i = 1'b0;
    logic wake_i = 1'b0;
    logic [7:0] mask_control_i = 8'he2, mask_autoload_i = 8'h03, pulses = 8'h00, d;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
    logic sfr_wr_i, sfr_rd_i, system_reset_o, timeout_flag_o;
    logic power_down_o, idle_o;
    int fail_count = 0, check_count = 0, n;
    always #2.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (system_reset_o === 1'b1) pulses <= pulses + 8'h01;
    wdt_sw_model sw (.clk_i(clk_sys_i), .rdata_i(sfr_rdata_o), .addr_o(sfr_addr_i),
        .wdata_o(sfr_wdata_i), .wr_o(sfr_wr_i), .rd_o(sfr_rd_i));
    wdt_core DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .por_i(por_i),
        .rom_variant_i(rom_variant_i), .external_access_select_i(external_access_select_i),
        .mask_control_i(mask_control_i), .mask_autoload_i(mask_autoload_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i), .low_voltage_i(low_voltage_i), .osc_fail_i(osc_fail_i),
        .wake_i(wake_i), .sfr_rdata_o(sfr_rdata_o), .system_reset_o(system_reset_o),
        .timeout_flag_o(timeout_flag_o), .power_down_o(power_down_o), .idle_o(idle_o));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wait_flag(output int cnt);
        cnt = 0;
        while (timeout_flag_o !== 1'b1 && cnt < 2000) begin
            cyc(1);
            cnt++;
        end
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // The tests need about 2230 cycles, so 20000 leaves ample margin.
    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
    initial begin
        cyc(6);
        rst_n_i = 1'b1;
        por_i = 1'b0;
        foreach (ROWS[i]) begin
            rom_variant_i = ROWS[i].rom;
            external_access_select_i = ROWS[i].ea;
            sw.rd(ROWS[i].addr, d);
            check("register read", d, ROWS[i].exp);
        end
        rom_variant_i = 1'b0;
        external_access_select_i = 1'b0;
        sw.wr(wdt_pkg::ADDR_WDL, 8'h05);
        sw.wr(wdt_pkg::ADDR_WATCHDOG_CONTROL, 8'h1a);
        sw.rd(wdt_pkg::ADDR_WATCHDOG_CONTROL, d);
        check("control user copy", d, 8'h1a);
        sw.feed(wdt_pkg::FEED2_KEY);
        wait_flag(n);
        check("timer time-out", {7'h00, n >= 767 && n <= 769}, 8'h01);
        check("timer no reset", pulses, 8'h00);
        sw.wr(wdt_pkg::ADDR_POWER_CONTROL_REG, 8'h00);
        check("flag clear", {7'h00, timeout_flag_o}, 8'h00);
        sw.wr(wdt_pkg::ADDR_WATCHDOG_CONTROL, 8'h18);
        cyc(1000);
        check("run off", {7'h00, timeout_flag_o}, 8'h00);
        sw.wr(wdt_pkg::ADDR_WATCHDOG_CONTROL, 8'h1b);
        sw.wr(wdt_pkg::ADDR_WDL, 8'h02);
        sw.feed(wdt_pkg::FEED2_KEY);
        wait_flag(n);
        check("watchdog time-out", {7'h00, n >= 383 && n <= 385}, 8'h01);
        cyc(2);
        check("watchdog reset", pulses, 8'h01);
        sw.rd(wdt_pkg::ADDR_WATCHDOG_CONTROL, d);
        check("control kept", d, 8'h1b);
        sw.wr(wdt_pkg::ADDR_POWER_CONTROL_REG, 8'h00);
        sw.feed(8'h00);
        check("forced underflow", {7'h00, timeout_flag_o}, 8'h01);
        low_voltage_i = 1'b1;
        cyc(2);
        check("low voltage reset", {7'h00, system_reset_o}, 8'h01);
        low_voltage_i = 1'b0;
        sw.wr(wdt_pkg::ADDR_WATCHDOG_CONTROL, 8'h0b);
        sw.feed(wdt_pkg::FEED2_KEY);
        low_voltage_i = 1'b1;
        cyc(2);
        check("low voltage blocked", {7'h00, system_reset_o}, 8'h00);
        low_voltage_i = 1'b0;
        osc_fail_i = 1'b1;
        cyc(2);
        check("osc fail reset", {7'h00, system_reset_o}, 8'h01);
        osc_fail_i = 1'b0;
        // Keep bit 4 set so the time-out flag survives these power control writes.
        sw.wr(wdt_pkg::ADDR_POWER_CONTROL_REG, 8'h13);
        check("power down entry", {7'h00, power_down_o}, 8'h01);
        check("idle entry", {7'h00, idle_o}, 8'h01);
        wake_i = 1'b1;
        cyc(1);
        wake_i = 1'b0;
        check("power down wake", {7'h00, power_down_o}, 8'h00);
        check("idle wake", {7'h00, idle_o}, 8'h00);
        sw.wr(wdt_pkg::ADDR_WATCHDOG_CONTROL, 8'h0f);
        sw.feed(wdt_pkg::FEED2_KEY);
        sw.wr(wdt_pkg::ADDR_POWER_CONTROL_REG, 8'h12);
        check("power down refused", {7'h00, power_down_o}, 8'h00);
        rst_n_i = 1'b0;
        cyc(2);
        rst_n_i = 1'b1;
        sw.rd(wdt_pkg::ADDR_WATCHDOG_CONTROL, d);
        check("control after reset", d, 8'hfb);
        sw.rd(wdt_pkg::ADDR_POWER_CONTROL_REG, d);
        check("flag over reset", d, 8'h10);
        give_verdict();
    end
endmodule // tb

// ### bench/wdt_core_props.sv
// Concurrent checks on the watchdog core ports.
module wdt_core_props (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic por_i,
    input wire logic rom_variant_i,
    input wire logic external_access_select_i,
    input wire logic [7:0] mask_control_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic low_voltage_i,
    input wire logic osc_fail_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic system_reset_o,
    input wire logic timeout_flag_o,
    input wire logic power_down_o,
    input wire logic idle_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    AST_RESET_STATE: assert property ($rose(rst_n_i) |-> sfr_rdata_o == 8'h00 && !power_down_o && !idle_o) else $error("outputs not cleared by reset");
    AST_FLAG_STICKY: assert property (timeout_flag_o && !por_i && !(sfr_wr_i && sfr_addr_i == wdt_pkg::ADDR_POWER_CONTROL_REG) |=> timeout_flag_o) else $error("flag cleared by hardware");
    AST_RESET_SETS_FLAG: assert property (system_reset_o && !$past(low_voltage_i) && !$past(osc_fail_i) |-> timeout_flag_o) else $error("underflow reset without flag");
    AST_RESET_PULSE_ONE: assert property (system_reset_o && $past(system_reset_o) |-> $past(low_voltage_i) || $past(osc_fail_i)) else $error("underflow reset longer than a cycle");
    AST_BAD_KEY_UNDERFLOW: assert property (sfr_wr_i && sfr_addr_i == wdt_pkg::ADDR_FEED1 && sfr_wdata_i == wdt_pkg::FEED1_KEY ##1 sfr_wr_i && sfr_addr_i == wdt_pkg::ADDR_FEED2 && sfr_wdata_i != wdt_pkg::FEED2_KEY |=> timeout_flag_o) else $error("bad second key did not underflow");
    AST_FLAG_READBACK: assert property (sfr_rd_i && sfr_addr_i == wdt_pkg::ADDR_POWER_CONTROL_REG |=> sfr_rdata_o[wdt_pkg::POWER_CONTROL_REG_TOF] == $past(timeout_flag_o)) else $error("flag readback wrong");
    AST_MASK_MODE_READ: assert property (rom_variant_i && external_access_select_i && sfr_rd_i && sfr_addr_i == wdt_pkg::ADDR_WATCHDOG_CONTROL |=> sfr_rdata_o[0] == mask_control_i[0]) else $error("mode bit not mask value");
    AST_USER_COPY: assert property (sfr_wr_i && sfr_addr_i == wdt_pkg::ADDR_WATCHDOG_CONTROL && !(rom_variant_i && external_access_select_i) ##1 !sfr_wr_i ##1 sfr_rd_i && sfr_addr_i == wdt_pkg::ADDR_WATCHDOG_CONTROL |=> sfr_rdata_o == $past(sfr_wdata_i, 3)) else $error("control readback wrong");
    COV_FLAG: cover property ($rose(timeout_flag_o));
    COV_SYS_RESET: cover property ($rose(system_reset_o));
    COV_READ: cover property (sfr_rd_i && sfr_addr_i == wdt_pkg::ADDR_WATCHDOG_CONTROL);
endmodule // wdt_core_props
bind wdt_core wdt_core_props u_props (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .por_i(por_i),
    .rom_variant_i(rom_variant_i), .external_access_select_i(external_access_select_i),
    .mask_control_i(mask_control_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .low_voltage_i(low_voltage_i),
    .osc_fail_i(osc_fail_i), .sfr_rdata_o(sfr_rdata_o), .system_reset_o(system_reset_o),
    .timeout_flag_o(timeout_flag_o), .power_down_o(power_down_o), .idle_o(idle_o));

// ### bench/wdt_sw_model.sv
// Software model that drives the special function register bus.
module wdt_sw_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Released lines show the inverse of their last value, so a stale copy is never read.
    task automatic release_bus();
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
        @(posedge clk_i);
        #1;
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        put(a, d);
        release_bus();
    endtask
    // Both keys go out on consecutive edges, since no other write may slip between them.
    task automatic feed(input logic [7:0] second);
        put(wdt_pkg::ADDR_FEED1, wdt_pkg::FEED1_KEY);
        put(wdt_pkg::ADDR_FEED2, second);
        release_bus();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        d = rdata_i;
        release_bus();
    endtask
endmodule // wdt_sw_model

// ### src/wdt_core.sv
// Watchdog timer subsystem: control registers, feed sequence and main down-counter.
//
// How it works
// - Mask values when ROM part and pin high.
// - Mask timer mode keeps register autoload and tap.
// - Run bit gates timer mode only, no feed.
// - External reset restores watchdog defaults and autoloads.
// - Valid feed reloads counter in timer mode too.
// - Underflow during reset still sets time-out flag.
// - Watchdog underflow autoloads, flags, resets the system.
// - Only software or power-on clears the flag.
// - Timer underflow autoloads and flags, no reset.
// - Mask mode bit reads back; run ignored.
// - Divide by 2, 13 stages, eight taps.
// - Counter decrements per tick, underflows from zero.
// - Any autoload value; autoload clears prescaler.
// - Time-out is 128 times 2^tap times (W+1).
// - Mask-coded control bits; run read-only in mask watchdog mode.
// - Control writes apply only on valid feed, run bit excepted.
// - Reset gives watchdog mode, no interrupt exists.
// - Control changes other than run take effect only through feed.
// - Bits 4 and 3 gate detector resets.
// - Tap, power-down disable, run, mode bit layout.
// - Time-out flag lives in power control register.
// - Feed writes must be back to back.
// - Good first key, bad second forces underflow.
module wdt_core (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic por_i,
    input wire logic rom_variant_i,
    input wire logic external_access_select_i,
    input wire logic [7:0] mask_control_i,
    input wire logic [7:0] mask_autoload_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic low_voltage_i,
    input wire logic osc_fail_i,
    input wire logic wake_i,
    output logic [7:0] sfr_rdata_o,
    output logic system_reset_o,
    output logic timeout_flag_o,
    output logic power_down_o,
    output logic idle_o
);

    // Register file.
    logic [7:0] user_ctrl_reg;
    logic [7:0] active_ctrl_reg;
    logic wd_run_enable_reg;
    logic [7:0] autoload_value_reg;
    logic timeout_flag_reg;
    logic power_down_reg;
    logic idle_reg;
    logic [7:0] rdata_reg;
    logic system_reset_reg;

    // Counter and feed sequencer.
    logic [7:0] count_reg;
    logic [7:0] count_next;
    wdt_pkg::wdt_feed_e feed_state_reg;
    wdt_pkg::wdt_feed_e feed_state_next;

    // Decoded accesses.
    logic wr_watchdog_control;
    logic wr_wdl;
    logic wr_feed1;
    logic wr_feed2;
    logic wr_power_control_reg;

    // Effective parameters after the mask or register choice.
    logic mask_sel;
    logic mask_wd_mode;
    logic wd_mode_select;
    logic [2:0] eff_tap;
    logic [7:0] eff_autoload;
    logic power_down_disable;
    logic low_voltage_reset_en;
    logic osc_fail_reset_en;
    logic run_ro;
    logic count_en;

    // Events.
    logic feed_ok;
    logic feed_bad;
    logic natural_uf;
    logic underflow;
    logic autoload;
    logic [7:0] watchdog_control_view;
    logic [7:0] rdata_next;

    wdt_presc_if presc_bus ();

    wdt_prescaler u_presc (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .presc(presc_bus.presc)
    );

    assign wr_watchdog_control = sfr_wr_i && (sfr_addr_i == wdt_pkg::ADDR_WATCHDOG_CONTROL);
    assign wr_wdl = sfr_wr_i && (sfr_addr_i == wdt_pkg::ADDR_WDL);
    assign wr_feed1 = sfr_wr_i && (sfr_addr_i == wdt_pkg::ADDR_FEED1);
    assign wr_feed2 = sfr_wr_i && (sfr_addr_i == wdt_pkg::ADDR_FEED2);
    assign wr_power_control_reg = sfr_wr_i && (sfr_addr_i == wdt_pkg::ADDR_POWER_CONTROL_REG);

    // Mask values apply only on the ROM variant with the pin high.
    assign mask_sel = rom_variant_i && external_access_select_i;
    assign mask_wd_mode = mask_sel && mask_control_i[wdt_pkg::BIT_MODE];

    always_comb begin
        if (mask_sel) begin
            wd_mode_select = mask_control_i[wdt_pkg::BIT_MODE];
            power_down_disable = mask_control_i[wdt_pkg::BIT_DPD];
            low_voltage_reset_en = mask_control_i[wdt_pkg::BIT_LOW_VOLTAGE_RESET_EN];
            osc_fail_reset_en = mask_control_i[wdt_pkg::BIT_OSC_FAIL_RESET_EN];
        end else begin
            wd_mode_select = active_ctrl_reg[wdt_pkg::BIT_MODE];
            power_down_disable = active_ctrl_reg[wdt_pkg::BIT_DPD];
            low_voltage_reset_en = active_ctrl_reg[wdt_pkg::BIT_LOW_VOLTAGE_RESET_EN];
            osc_fail_reset_en = active_ctrl_reg[wdt_pkg::BIT_OSC_FAIL_RESET_EN];
        end
    end

    // In mask timer mode the tap and autoload still come from the registers.
    always_comb begin
        if (mask_wd_mode) begin
            eff_tap = mask_control_i[wdt_pkg::TAP_MSB:wdt_pkg::TAP_LSB];
            eff_autoload = mask_autoload_i;
        end else begin
            eff_tap = active_ctrl_reg[wdt_pkg::TAP_MSB:wdt_pkg::TAP_LSB];
            eff_autoload = autoload_value_reg;
        end
    end

    // Watchdog mode always counts, so a stray write cannot stop it.
    assign count_en = wd_mode_select || wd_run_enable_reg;
    assign run_ro = mask_wd_mode;

    // Feed decode: the second key must be the very next write after the first.
    always_comb begin
        feed_ok = (feed_state_reg == wdt_pkg::FEED_ARMED) && wr_feed2
            && (sfr_wdata_i == wdt_pkg::FEED2_KEY);
        feed_bad = (feed_state_reg == wdt_pkg::FEED_ARMED) && wr_feed2
            && (sfr_wdata_i != wdt_pkg::FEED2_KEY);
    end

    always_comb begin
        case (feed_state_reg)
            wdt_pkg::FEED_IDLE: begin
                if (wr_feed1 && (sfr_wdata_i == wdt_pkg::FEED1_KEY)) begin
                    feed_state_next = wdt_pkg::FEED_ARMED;
                end else begin
                    feed_state_next = wdt_pkg::FEED_IDLE;
                end
            end
            wdt_pkg::FEED_ARMED: begin
                if (wr_feed1 && (sfr_wdata_i == wdt_pkg::FEED1_KEY)) begin
                    feed_state_next = wdt_pkg::FEED_ARMED;
                end else if (sfr_wr_i) begin
                    feed_state_next = wdt_pkg::FEED_IDLE;
                end else begin
                    feed_state_next = wdt_pkg::FEED_ARMED;
                end
            end
            default: begin
                feed_state_next = wdt_pkg::FEED_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            feed_state_reg <= wdt_pkg::FEED_IDLE;
        end else begin
            feed_state_reg <= feed_state_next;
        end
    end

    // Underflow comes from a tick at zero or from a broken feed.
    assign natural_uf = presc_bus.tick && count_en && (count_reg == wdt_pkg::COUNT_ZERO);
    assign underflow = natural_uf || feed_bad;
    assign autoload = underflow || feed_ok;

    // Every autoload restarts the prescaler, which makes an autoload of zero a full period.
    assign presc_bus.clear = autoload;
    assign presc_bus.tap = eff_tap;

    always_comb begin
        if (autoload) begin
            count_next = eff_autoload;
        end else if (presc_bus.tick && count_en) begin
            count_next = count_reg - wdt_pkg::COUNT_ONE;
        end else begin
            count_next = count_reg;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            if (mask_wd_mode) begin
                count_reg <= mask_autoload_i;
            end else begin
                count_reg <= wdt_pkg::WDL_RESET;
            end
        end else begin
            count_reg <= count_next;
        end
    end

    // Writes land in the user copy; the active copy follows only a valid feed.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            user_ctrl_reg <= wdt_pkg::WATCHDOG_CONTROL_RESET;
        end else if (wr_watchdog_control) begin
            user_ctrl_reg <= sfr_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            active_ctrl_reg <= wdt_pkg::WATCHDOG_CONTROL_RESET;
        end else if (feed_ok) begin
            active_ctrl_reg <= user_ctrl_reg;
        end
    end

    // Underflow leaves run, mode, tap and autoload value untouched.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            wd_run_enable_reg <= 1'b1;
        end else if (wr_watchdog_control && !run_ro) begin
            wd_run_enable_reg <= sfr_wdata_i[wdt_pkg::BIT_RUN];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            autoload_value_reg <= wdt_pkg::WDL_RESET;
        end else if (wr_wdl) begin
            autoload_value_reg <= sfr_wdata_i;
        end
    end

    // The flag has no reset term; of the resets only power-on clears it so it starts defined.
    always_ff @(posedge clk_sys_i) begin
        if (underflow) begin
            timeout_flag_reg <= 1'b1;
        end else if (por_i) begin
            timeout_flag_reg <= 1'b0;
        end else if (rst_n_i && wr_power_control_reg) begin
            timeout_flag_reg <= sfr_wdata_i[wdt_pkg::POWER_CONTROL_REG_TOF];
        end
    end

    // Power-down is refused while power-down disable is active.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            power_down_reg <= 1'b0;
            idle_reg <= 1'b0;
        end else if (wr_power_control_reg) begin
            power_down_reg <= sfr_wdata_i[wdt_pkg::POWER_CONTROL_REG_PD] && !power_down_disable;
            idle_reg <= sfr_wdata_i[wdt_pkg::POWER_CONTROL_REG_IDLE];
        end else if (wake_i) begin
            power_down_reg <= 1'b0;
            idle_reg <= 1'b0;
        end
    end

    // Watchdog mode underflow and the enabled detector resets reach the system; timer underflow does not, and there is no interrupt path.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            system_reset_reg <= 1'b0;
        end else begin
            system_reset_reg <= (underflow && wd_mode_select)
                || (low_voltage_i && low_voltage_reset_en)
                || (osc_fail_i && osc_fail_reset_en);
        end
    end

    // Control readback: mask-coded bits show through per bit when selected.
    for (genvar b = 0; b < 8; b++) begin : g_view
        if (b == wdt_pkg::BIT_RUN) begin : g_run
            assign watchdog_control_view[b] = wd_run_enable_reg;
        end else begin : g_ctl
            assign watchdog_control_view[b] = mask_sel ? mask_control_i[b] : user_ctrl_reg[b];
        end
    end

    always_comb begin
        case (sfr_addr_i)
            wdt_pkg::ADDR_WATCHDOG_CONTROL: begin
                rdata_next = watchdog_control_view;
            end
            wdt_pkg::ADDR_WDL: begin
                rdata_next = autoload_value_reg;
            end
            wdt_pkg::ADDR_POWER_CONTROL_REG: begin
                rdata_next = wdt_pkg::RDATA_RESET;
                rdata_next[wdt_pkg::POWER_CONTROL_REG_TOF] = timeout_flag_reg;
                rdata_next[wdt_pkg::POWER_CONTROL_REG_PD] = power_down_reg;
                rdata_next[wdt_pkg::POWER_CONTROL_REG_IDLE] = idle_reg;
            end
            default: begin
                rdata_next = wdt_pkg::RDATA_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rdata_reg <= wdt_pkg::RDATA_RESET;
        end else if (sfr_rd_i) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= wdt_pkg::RDATA_RESET;
        end
    end

    assign sfr_rdata_o = rdata_reg;
    assign system_reset_o = system_reset_reg;
    assign timeout_flag_o = timeout_flag_reg;
    assign power_down_o = power_down_reg;
    assign idle_o = idle_reg;

endmodule // wdt_core

// ### src/wdt_pkg.sv
// Constants and types shared by the watchdog timer subsystem.
package wdt_pkg;

    // Special function register addresses.
    localparam logic [7:0] ADDR_POWER_CONTROL_REG = 8'h87;
    localparam logic [7:0] ADDR_WDL = 8'hc1;
    localparam logic [7:0] ADDR_FEED1 = 8'hc2;
    localparam logic [7:0] ADDR_FEED2 = 8'hc3;
    localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'hc4;

    // Feed sequence keys.
    localparam logic [7:0] FEED1_KEY = 8'ha5;
    localparam logic [7:0] FEED2_KEY = 8'h5a;

    // Control register field positions.
    localparam int BIT_MODE = 0;
    localparam int BIT_RUN = 1;
    localparam int BIT_DPD = 2;
    localparam int BIT_OSC_FAIL_RESET_EN = 3;
    localparam int BIT_LOW_VOLTAGE_RESET_EN = 4;
    localparam int TAP_LSB = 5;
    localparam int TAP_MSB = 7;

    // Power control register field positions.
    localparam int POWER_CONTROL_REG_IDLE = 0;
    localparam int POWER_CONTROL_REG_PD = 1;
    localparam int POWER_CONTROL_REG_TOF = 4;

    // Values after reset.
    localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'hfb;
    localparam logic [7:0] WDL_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [7:0] COUNT_ONE = 8'h01;
    localparam logic [7:0] COUNT_ZERO = 8'h00;

    // Prescaler: divide by 2, then 13 stages, taps at stages 6 to 13.
    localparam int PRESC_DIV2_BITS = 1;
    localparam int PRESC_STAGES = 13;
    localparam int PRESC_FIRST_TAP = 6;
    localparam int PRESC_WIDTH = PRESC_DIV2_BITS + PRESC_STAGES;
    localparam int PRESC_BASE_BITS = PRESC_DIV2_BITS + PRESC_FIRST_TAP;
    localparam logic [PRESC_WIDTH-1:0] PRESC_ONE = 14'h0001;

    // Shortest time-out in oscillator periods: 2 times 64.
    localparam int TMIN_CYCLES = 2 * 64;

    typedef enum logic [0:0] {
        FEED_IDLE = 1'b0,
        FEED_ARMED = 1'b1
    } wdt_feed_e;

endpackage

// ### src/wdt_presc_if.sv
// Link between the watchdog core and its prescaler.
interface wdt_presc_if;
    logic clear;
    logic [2:0] tap;
    logic tick;

    modport ctrl (output clear, output tap, input tick);
    modport presc (input clear, input tap, output tick);
endinterface

// ### src/wdt_prescaler.sv
// Watchdog prescaler with selectable overflow tap.
module wdt_prescaler (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    wdt_presc_if.presc presc
);

    logic [wdt_pkg::PRESC_WIDTH-1:0] stage_reg;
    logic tick_reg;
    logic [wdt_pkg::PRESC_WIDTH-1:0] tap_mask;

    // The low bit is the divide by 2; the selected tap overflows when all bits below it are set.
    always_comb begin
        tap_mask = ~({wdt_pkg::PRESC_WIDTH{1'b1}} << (wdt_pkg::PRESC_BASE_BITS + int'(presc.tap)));
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || presc.clear) begin
            stage_reg <= '0;
        end else begin
            stage_reg <= stage_reg + wdt_pkg::PRESC_ONE;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || presc.clear) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= ((stage_reg & tap_mask) == tap_mask);
        end
    end

    assign presc.tick = tick_reg;

endmodule // wdt_prescaler
